// file: logic/fsc_cmd.sv
// Purpose: serial command handling for id, status, config reads and register write
// Assumes: serial clock far slower than reference clock
// Notes: select, clock, data and write protect pins pass a two stage synchroniser
`timescale 1ns/100ps
module fsc_cmd #(
	parameter int WRITE_CYCLES = fsc_pkg::WRITE_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic [3:0] i_io,
	input wire logic i_wp_n,
	input wire logic [7:0] i_config2_volatile,
	input wire logic [7:0] i_status2,
	input wire logic i_program_fail,
	input wire logic i_erase_fail,
	output logic [3:0] o_io,
	output logic [3:0] o_io_oe,
	output logic [7:0] o_status1_volatile,
	output logic [7:0] o_status1_nonvolatile,
	output logic [7:0] o_config1_volatile,
	output logic [7:0] o_config1_nonvolatile,
	output logic o_write_in_progress,
	output logic o_write_enable_latch
);
	typedef struct packed {
		logic cs_m;
		logic cs_s;
		logic sck_m;
		logic sck_s;
		logic sck_d;
		logic [3:0] io_m;
		logic [3:0] io_s;
		logic wp_m;
		logic wp_s;
		fsc_pkg::fsc_state_t state;
		fsc_pkg::fsc_src_t src;
		logic quad;
		logic [7:0] cmd;
		logic [5:0] cnt;
		logic [15:0] data;
		logic [4:0] dcnt;
		logic [7:0] sh;
		logic [3:0] obits;
		logic [2:0] idx;
		logic [3:0] io_out;
		logic [3:0] io_oe;
		logic [7:0] status1_volatile;
		logic [7:0] status1_nonvolatile;
		logic [7:0] config1_volatile;
		logic [7:0] config1_nonvolatile;
		logic [15:0] timer;
		logic pend_two;
		logic [7:0] pend_sr;
		logic [7:0] pend_cr;
	} fsc_st_t;

	fsc_st_t st;
	fsc_st_t next_st;
	logic [7:0] uid_byte;
	logic sck_rise;
	logic sck_fall;
	logic frame_end;
	logic wrr_end;
	logic write_enable_cmd_end;
	logic protect_lock;
	logic start_ok;
	logic write_done;
	logic write_err;

	function automatic logic [5:0] fsc_step(input logic quad);
		fsc_step = quad ? 6'h04 : 6'h01;
	endfunction : fsc_step

	function automatic logic [7:0] fsc_shift_in(input logic [7:0] cur, input logic quad, input logic [3:0] io);
		fsc_shift_in = quad ? {cur[3:0], io} : {cur[6:0], io[0]};
	endfunction : fsc_shift_in

	fsc_uid_rom u_uid (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_addr(st.idx),
		.o_data(uid_byte)
	);

	always_comb begin
		logic [5:0] cnt_nx;
		logic [7:0] obyte;
		logic [4:0] dstep;
		cnt_nx = 6'h00;
		obyte = 8'h00;
		dstep = 5'h00;
		next_st = st;
		next_st.cs_m = i_cs_n;
		next_st.cs_s = st.cs_m;
		next_st.sck_m = i_sck;
		next_st.sck_s = st.sck_m;
		next_st.sck_d = st.sck_s;
		next_st.io_m = i_io;
		next_st.io_s = st.io_m;
		next_st.wp_m = i_wp_n;
		next_st.wp_s = st.wp_m;
		sck_rise = st.sck_s & ~st.sck_d;
		sck_fall = ~st.sck_s & st.sck_d;
		frame_end = st.cs_s & (st.state != fsc_pkg::FSC_IDLE);
		wrr_end = frame_end & (st.state == fsc_pkg::FSC_DATA) & (st.cmd == fsc_pkg::OP_WRR)
			& ((st.dcnt == fsc_pkg::ONE_BYTE_BITS) | (st.dcnt == fsc_pkg::TWO_BYTE_BITS));
		write_enable_cmd_end = frame_end & (st.state == fsc_pkg::FSC_DONE) & (st.cmd == fsc_pkg::OP_WRITE_ENABLE_CMD)
			& (st.dcnt == 5'h00);
		protect_lock = st.status1_volatile[fsc_pkg::STATUS_WRITE_DISABLE_BIT] & ~st.wp_s;
		start_ok = wrr_end & st.status1_volatile[fsc_pkg::WEL_BIT] & ~st.status1_volatile[fsc_pkg::WIP_BIT] & ~protect_lock;
		write_done = st.status1_volatile[fsc_pkg::WIP_BIT] & (st.timer == 16'h0001);
		write_err = i_program_fail | i_erase_fail;
		cnt_nx = st.cnt + fsc_step(st.quad);
		dstep = st.quad ? 5'h04 : 5'h01;

		if (st.status1_volatile[fsc_pkg::WIP_BIT] && st.timer > 16'h0001) begin
			next_st.timer = st.timer - 16'h0001;
		end
		if (write_done) begin
			next_st.timer = 16'h0000;
			next_st.status1_volatile[fsc_pkg::WIP_BIT] = 1'b0;
			next_st.status1_volatile[fsc_pkg::WEL_BIT] = 1'b0;
			if (write_err) begin
				next_st.status1_volatile[fsc_pkg::PERR_BIT] = st.status1_volatile[fsc_pkg::PERR_BIT] | i_program_fail;
				next_st.status1_volatile[fsc_pkg::EERR_BIT] = st.status1_volatile[fsc_pkg::EERR_BIT] | i_erase_fail;
			end else begin
				next_st.status1_volatile[fsc_pkg::STATUS_WRITE_DISABLE_BIT] = st.pend_sr[fsc_pkg::STATUS_WRITE_DISABLE_BIT];
				next_st.status1_nonvolatile[fsc_pkg::STATUS_WRITE_DISABLE_BIT] = st.pend_sr[fsc_pkg::STATUS_WRITE_DISABLE_BIT];
				next_st.status1_volatile[fsc_pkg::BP_HI:fsc_pkg::BP_LO] = st.pend_sr[fsc_pkg::BP_HI:fsc_pkg::BP_LO];
				if (!st.config1_nonvolatile[fsc_pkg::BPSEL_BIT]) begin
					next_st.status1_nonvolatile[fsc_pkg::BP_HI:fsc_pkg::BP_LO] = st.pend_sr[fsc_pkg::BP_HI:fsc_pkg::BP_LO];
				end
				if (st.pend_two) begin
					next_st.config1_volatile = st.pend_cr;
					next_st.config1_nonvolatile = st.pend_cr;
				end
			end
		end

		if (st.cs_s) begin
			next_st.state = fsc_pkg::FSC_IDLE;
			next_st.io_oe = 4'h0;
			next_st.io_out = 4'h0;
			if (write_enable_cmd_end) begin
				next_st.status1_volatile[fsc_pkg::WEL_BIT] = 1'b1;
			end
			if (start_ok) begin
				next_st.status1_volatile[fsc_pkg::WIP_BIT] = 1'b1;
				next_st.timer = 16'(WRITE_CYCLES);
				next_st.pend_two = (st.dcnt == fsc_pkg::TWO_BYTE_BITS);
				next_st.pend_sr = (st.dcnt == fsc_pkg::TWO_BYTE_BITS) ? st.data[15:8] : st.data[7:0];
				next_st.pend_cr = st.data[7:0];
			end
		end else begin
			case (st.state)
				fsc_pkg::FSC_IDLE: begin
					next_st.state = fsc_pkg::FSC_CMD;
					next_st.quad = i_config2_volatile[fsc_pkg::QUAD_BIT];
					next_st.cnt = 6'h00;
					next_st.cmd = 8'h00;
					next_st.dcnt = 5'h00;
					next_st.data = 16'h0000;
				end
				fsc_pkg::FSC_CMD: begin
					if (sck_rise) begin
						next_st.cmd = fsc_shift_in(st.cmd, st.quad, st.io_s);
						next_st.cnt = cnt_nx;
						if (cnt_nx == fsc_pkg::CMD_BITS) begin
							next_st.cnt = 6'h00;
							next_st.obits = 4'h0;
							next_st.idx = 3'h0;
							next_st.state = fsc_pkg::FSC_OUT;
							case (fsc_shift_in(st.cmd, st.quad, st.io_s))
								fsc_pkg::OP_UID: begin
									next_st.state = fsc_pkg::FSC_DUMMY;
									next_st.src = fsc_pkg::FSC_SRC_UID;
								end
								fsc_pkg::OP_SR1: begin
									next_st.src = fsc_pkg::FSC_SRC_SR1;
								end
								fsc_pkg::OP_SR2: begin
									next_st.src = fsc_pkg::FSC_SRC_SR2;
									if (st.quad) begin
										next_st.state = fsc_pkg::FSC_DONE;
									end
								end
								fsc_pkg::OP_CR1: begin
									next_st.src = fsc_pkg::FSC_SRC_CR1;
									if (st.quad) begin
										next_st.state = fsc_pkg::FSC_DONE;
									end
								end
								fsc_pkg::OP_WRR: begin
									next_st.state = fsc_pkg::FSC_DATA;
								end
								default: begin
									next_st.state = fsc_pkg::FSC_DONE;
								end
							endcase
						end
					end
				end
				fsc_pkg::FSC_DUMMY: begin
					if (sck_rise) begin
						next_st.cnt = st.cnt + 6'h01;
						if (st.cnt + 6'h01 == fsc_pkg::UID_DUMMY_CLKS) begin
							next_st.state = fsc_pkg::FSC_OUT;
						end
					end
				end
				fsc_pkg::FSC_OUT: begin
					if (sck_fall) begin
						if (st.obits == 4'h0) begin
							case (st.src)
								fsc_pkg::FSC_SRC_UID: obyte = uid_byte;
								fsc_pkg::FSC_SRC_SR1: obyte = st.status1_volatile;
								fsc_pkg::FSC_SRC_SR2: obyte = i_status2;
								default: obyte = st.config1_volatile;
							endcase
							next_st.idx = st.idx + 3'h1;
						end else begin
							obyte = st.sh;
						end
						if (st.quad) begin
							next_st.io_out = obyte[7:4];
							next_st.io_oe = 4'hF;
							next_st.sh = {obyte[3:0], 4'h0};
						end else begin
							next_st.io_out = {2'b00, obyte[7], 1'b0};
							next_st.io_oe = 4'h2;
							next_st.sh = {obyte[6:0], 1'b0};
						end
						next_st.obits = (st.obits + 4'(fsc_step(st.quad)) == 4'h8) ? 4'h0
							: st.obits + 4'(fsc_step(st.quad));
					end
				end
				fsc_pkg::FSC_DATA: begin
					if (sck_rise) begin
						next_st.data = st.quad ? {st.data[11:0], st.io_s} : {st.data[14:0], st.io_s[0]};
						if (st.dcnt < fsc_pkg::DATA_SAT_BITS) begin
							next_st.dcnt = st.dcnt + dstep;
						end
					end
				end
				fsc_pkg::FSC_DONE: begin
					if (sck_rise) begin
						next_st.dcnt = 5'h01;
					end
				end
				default: begin
					next_st.state = fsc_pkg::FSC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			st <= '0;
			st.cs_m <= 1'b1;
			st.cs_s <= 1'b1;
			st.wp_m <= 1'b1;
			st.wp_s <= 1'b1;
			st.status1_volatile <= fsc_pkg::SR1_RESET;
			st.status1_nonvolatile <= fsc_pkg::SR1_RESET;
			st.config1_volatile <= fsc_pkg::CR1_RESET;
			st.config1_nonvolatile <= fsc_pkg::CR1_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign o_io = st.io_out;
	assign o_io_oe = st.io_oe;
	assign o_status1_volatile = st.status1_volatile;
	assign o_status1_nonvolatile = st.status1_nonvolatile;
	assign o_config1_volatile = st.config1_volatile;
	assign o_config1_nonvolatile = st.config1_nonvolatile;
	assign o_write_in_progress = st.status1_volatile[fsc_pkg::WIP_BIT];
	assign o_write_enable_latch = st.status1_volatile[fsc_pkg::WEL_BIT];

	wip_start_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		start_ok |=> st.status1_volatile[fsc_pkg::WIP_BIT] ##1 st.status1_volatile[fsc_pkg::WIP_BIT][*3])
		else $error("busy flag not held after register write start");
	wel_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		$fell(st.status1_volatile[fsc_pkg::WIP_BIT]) |-> !st.status1_volatile[fsc_pkg::WEL_BIT] || $past(write_enable_cmd_end))
		else $error("write enable latch still set after write");
	wel_needed_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		wrr_end && !st.status1_volatile[fsc_pkg::WEL_BIT] && !st.status1_volatile[fsc_pkg::WIP_BIT] |=> !st.status1_volatile[fsc_pkg::WIP_BIT])
		else $error("register write started without write enable");
	hw_lock_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		wrr_end && protect_lock && !st.status1_volatile[fsc_pkg::WIP_BIT]
		|=> !st.status1_volatile[fsc_pkg::WIP_BIT] && $stable(st.status1_volatile[7:2]) && $stable(st.config1_volatile))
		else $error("locked register write was not rejected");
	write_enable_cmd_set_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		write_enable_cmd_end |=> st.status1_volatile[fsc_pkg::WEL_BIT])
		else $error("write enable command did not set latch");
	cs_release_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		st.cs_s |=> st.io_oe == 4'h0)
		else $error("outputs driven with select high");
	dummy_quiet_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		st.state == fsc_pkg::FSC_DUMMY |-> st.io_oe == 4'h0)
		else $error("output driven during id latency");
	one_byte_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		write_done && !st.pend_two |=> $stable(st.config1_volatile) && $stable(st.config1_nonvolatile))
		else $error("one byte write changed config register");
	bp_target_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		write_done && !write_err && st.config1_nonvolatile[fsc_pkg::BPSEL_BIT] |=> $stable(st.status1_nonvolatile[4:2]))
		else $error("volatile target wrote nonvolatile protect bits");
	wip_done_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		write_done |=> !st.status1_volatile[fsc_pkg::WIP_BIT])
		else $error("busy flag not cleared at write completion");
	err_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		write_done && i_program_fail |=> st.status1_volatile[fsc_pkg::PERR_BIT])
		else $error("program error flag not set on failed write");
	lane_width_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		st.state == fsc_pkg::FSC_OUT && st.io_oe != 4'h0 |-> st.io_oe == (st.quad ? 4'hF : 4'h2))
		else $error("wrong output lanes for mode");
endmodule : fsc_cmd

// file: include/fsc_pkg.sv
// Purpose: constants and types for the flash status, config and unique id command block
// Assumes: serial clock sampled by a 100 MHz reference clock
// Notes: offsets are bit positions inside the register bytes
package fsc_pkg;
	localparam logic [7:0] OP_UID = 8'h4C;
	localparam logic [7:0] OP_SR1 = 8'h05;
	localparam logic [7:0] OP_SR2 = 8'h07;
	localparam logic [7:0] OP_CR1 = 8'h35;
	localparam logic [7:0] OP_WRR = 8'h01;
	localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
	localparam int WIP_BIT = 0;
	localparam int WEL_BIT = 1;
	localparam int BP_LO = 2;
	localparam int BP_HI = 4;
	localparam int EERR_BIT = 5;
	localparam int PERR_BIT = 6;
	localparam int STATUS_WRITE_DISABLE_BIT = 7;
	localparam int BPSEL_BIT = 3;
	localparam int QUAD_BIT = 6;
	localparam logic [5:0] UID_DUMMY_CLKS = 6'h20;
	localparam logic [5:0] CMD_BITS = 6'h08;
	localparam logic [4:0] ONE_BYTE_BITS = 5'h08;
	localparam logic [4:0] TWO_BYTE_BITS = 5'h10;
	localparam logic [4:0] DATA_SAT_BITS = 5'h18;
	localparam logic [7:0] SR1_RESET = 8'h00;
	localparam logic [7:0] CR1_RESET = 8'h00;
	localparam int REF_PERIOD_NS = 10;
	localparam int WRITE_TIME_NS = 2000;
	localparam int WRITE_CYC = (WRITE_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	typedef enum logic [2:0] {
		FSC_IDLE = 3'b000,
		FSC_CMD = 3'b001,
		FSC_DUMMY = 3'b011,
		FSC_OUT = 3'b010,
		FSC_DATA = 3'b110,
		FSC_DONE = 3'b111
	} fsc_state_t;
	typedef enum logic [1:0] {
		FSC_SRC_UID = 2'b00,
		FSC_SRC_SR1 = 2'b01,
		FSC_SRC_SR2 = 2'b11,
		FSC_SRC_CR1 = 2'b10
	} fsc_src_t;
endpackage : fsc_pkg

// file: logic/fsc_uid_rom.sv
// Purpose: factory unique id store, one byte per read
// Assumes: address stable a cycle before use
// Notes: read data registered
`timescale 1ns/100ps
module fsc_uid_rom #(
	parameter logic [63:0] UID = 64'h0123_4567_89AB_CDEF // arbitrary value
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic [2:0] i_addr,
	output logic [7:0] o_data
);
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_data <= 8'h00;
		end else begin
			o_data <= 8'(UID >> {3'h7 - i_addr, 3'h0});
		end
	end
endmodule : fsc_uid_rom

// file: verif/fsc_host.sv
// Purpose: host controller model for select, serial clock and data lines
// Assumes: mode 0, serial clock 80 ns, clock idle low outside frames
// Notes: frame sends, lets dummy clocks pass, then collects output bits
`timescale 1ns/100ps
module fsc_host (
	input wire logic i_ref_clk,
	input wire logic [3:0] i_io,
	output logic o_sck,
	output logic o_cs_n,
	output logic [3:0] o_io
);
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_io = 4'h0;
	end
	task automatic frame(input bit q, input logic [23:0] tx, input int ntx, input int ndum,
		input int nrx, output logic [63:0] rx);
		rx = '0;
		o_cs_n <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		for (int k = 0; k < ntx + ndum + nrx; k++) begin
			if (k < ntx) begin
				o_io <= q ? tx[23:20] : {~o_io[3:1], tx[23]};
				tx = q ? tx << 4 : tx << 1;
			end else begin
				o_io <= ~o_io;
			end
			repeat (4) @(posedge i_ref_clk);
			o_sck <= 1'b1;
			repeat (4) @(posedge i_ref_clk);
			if (k >= ntx + ndum)
				rx = q ? {rx[59:0], i_io} : {rx[62:0], i_io[1]};
			o_sck <= 1'b0;
		end
		repeat (4) @(posedge i_ref_clk);
		o_cs_n <= 1'b1;
		o_io <= ~o_io;
		repeat (12) @(posedge i_ref_clk);
	endtask : frame
endmodule : fsc_host

// file: verif/flash_status_config_uid_cmds_test.sv
// Purpose: self-checking bench for id, status, config reads and register write
// Assumes: write time set to 300 cycles through the write cycles parameter
// Notes: single mode first, then quad command mode
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module flash_status_config_uid_cmds_test;
	localparam int WCYC = 300;
	localparam logic [63:0] UID = 64'h0123_4567_89AB_CDEF;
	logic i_ref_clk, i_reset, i_wp_n, i_program_fail, i_erase_fail;
	logic [7:0] i_config2_volatile, i_status2;
	logic sck, cs_n, oe_seen, write_in_progress, write_enable_latch;
	logic [3:0] hio, o_io, o_io_oe;
	logic [7:0] s1v, s1nv, c1v, c1nv;
	logic [63:0] rx;
	int fail_count = 0;
	int check_count = 0;
	bit q = 0;
	fsc_cmd #(.WRITE_CYCLES(WCYC)) dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_sck(sck),
		.i_cs_n(cs_n), .i_io(hio), .i_wp_n(i_wp_n), .i_config2_volatile(i_config2_volatile),
		.i_status2(i_status2), .i_program_fail(i_program_fail), .i_erase_fail(i_erase_fail),
		.o_io(o_io), .o_io_oe(o_io_oe), .o_status1_volatile(s1v), .o_status1_nonvolatile(s1nv),
		.o_config1_volatile(c1v), .o_config1_nonvolatile(c1nv), .o_write_in_progress(write_in_progress),
		.o_write_enable_latch(write_enable_latch));
	fsc_host host (.i_ref_clk(i_ref_clk), .i_io(o_io), .o_sck(sck), .o_cs_n(cs_n), .o_io(hio));
	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	always @(posedge i_ref_clk) if (|o_io_oe) oe_seen <= 1'b1;
	task automatic cmd(input logic [7:0] op, input logic [15:0] d, input int nd, input int ndum,
		input int nrx);
		host.frame(q, {op, d}, q ? (8 + nd) / 4 : 8 + nd, ndum, q ? nrx / 4 : nrx, rx);
	endtask : cmd
	task automatic wr(input logic [15:0] d, input int nd);
		cmd(fsc_pkg::OP_WRITE_ENABLE_CMD, 16'h0000, 0, 0, 0);
		cmd(fsc_pkg::OP_WRR, d, nd, 0, 0);
	endtask : wr
	task automatic settle;
		for (int i = 0; i < WCYC + 40 && write_in_progress !== 1'b0; i++) @(posedge i_ref_clk);
		repeat (2) @(posedge i_ref_clk);
	endtask : settle
	task automatic regs(input logic [31:0] e);
		`CHK({s1v, s1nv, c1v, c1nv}, e)
	endtask : regs
	task automatic close_out;
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out
	initial begin
		repeat (40000) @(posedge i_ref_clk);
		fail_count++;
		close_out();
	end
	initial begin
		i_reset = 1'b1;
		i_wp_n = 1'b1;
		i_config2_volatile = 8'h00;
		i_status2 = 8'hA5;
		i_program_fail = 1'b0;
		i_erase_fail = 1'b0;
		oe_seen = 1'b0;
		repeat (2) @(posedge i_ref_clk);
		i_reset <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		regs(32'h0000_0000);
		`CHK({write_in_progress, write_enable_latch, o_io_oe}, 6'h00)
		cmd(fsc_pkg::OP_WRR, 16'hFC00, 8, 0, 0);
		settle();
		regs(32'h0000_0000);
		wr(16'h9C00, 8);
		`CHK(write_in_progress, 1'b1)
		cmd(fsc_pkg::OP_SR1, 16'h0000, 0, 0, 16);
		`CHK(rx[15:0], 16'h0303)
		settle();
		`CHK({write_in_progress, write_enable_latch}, 2'b00)
		regs(32'h9C9C_0000);
		i_wp_n <= 1'b0;
		wr(16'h1C08, 16);
		settle();
		regs(32'h9E9C_0000);
		i_wp_n <= 1'b1;
		wr(16'h1C08, 16);
		settle();
		regs(32'h1C1C_0808);
		i_wp_n <= 1'b0;
		wr(16'h0000, 8);
		settle();
		regs(32'h001C_0808);
		wr(16'hFFF0, 12);
		settle();
		regs(32'h021C_0808);
		cmd(fsc_pkg::OP_CR1, 16'h0000, 0, 0, 16);
		`CHK(rx[15:0], 16'h0808)
		cmd(fsc_pkg::OP_SR2, 16'h0000, 0, 0, 16);
		`CHK(rx[15:0], 16'hA5A5)
		cmd(fsc_pkg::OP_UID, 16'h0000, 0, 32, 72);
		`CHK(rx[63:8], UID[55:0])
		`CHK(o_io_oe, 4'h0)
		i_erase_fail <= 1'b1;
		i_program_fail <= 1'b1;
		wr(16'h0000, 8);
		settle();
		regs(32'h601C_0808);
		i_erase_fail <= 1'b0;
		i_program_fail <= 1'b0;
		i_config2_volatile <= 8'h40;
		q = 1'b1;
		oe_seen <= 1'b0;
		cmd(fsc_pkg::OP_SR2, 16'h0000, 0, 0, 16);
		`CHK(oe_seen, 1'b0)
		cmd(fsc_pkg::OP_UID, 16'h0000, 0, 32, 64);
		`CHK(rx, UID)
		wr(16'h0400, 8);
		wr(16'h1800, 8);
		settle();
		regs(32'h641C_0808);
		cmd(fsc_pkg::OP_SR1, 16'h0000, 0, 0, 16);
		`CHK(rx[15:0], 16'h6464)
		close_out();
	end
endmodule : flash_status_config_uid_cmds_test
